// ===== core/utc_cfg.svh
/*
 * constants of the ultrasonic time-of-flight control block: register
 * offsets, reset values, field positions and sequence counts.
 * assumes it is included by bare name wherever a constant is needed.
 */
`ifndef UTC_CFG_SVH
`define UTC_CFG_SVH

// ----------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------
`define UTC_A_TX_BURST   6'h00
`define UTC_A_RX_COUNT   6'h01
`define UTC_A_AFE_MODE   6'h02
`define UTC_A_THR_BLANK  6'h03
`define UTC_A_RX_MODE    6'h04
`define UTC_A_WAIT_HI    6'h05
`define UTC_A_WAIT_LO    6'h06
`define UTC_A_ERR        6'h07
`define UTC_A_LISTEN     6'h08
`define UTC_A_CLK_SCALE  6'h09

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define UTC_R_TX_BURST   8'h45
`define UTC_R_RX_COUNT   8'h40
`define UTC_R_AFE_MODE   8'h00
`define UTC_R_THR_BLANK  8'h03
`define UTC_R_RX_MODE    8'h1f
`define UTC_R_WAIT_HI    8'h00
`define UTC_R_WAIT_LO    8'h00
`define UTC_R_LISTEN     8'h19
`define UTC_R_CLK_SCALE  8'h00

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define UTC_NUM_TX       4:0
`define UTC_NUM_RX       2:0
`define UTC_THR          2:0
`define UTC_BLANK_BIT    3
`define UTC_TRIG_POL_BIT 5
`define UTC_WAIT_HI      1:0
`define UTC_WIN_SEL      1:0
`define UTC_TMO_DIS_BIT  2
`define UTC_FORCE_BIT    6
`define UTC_PRE_BIT      0
`define UTC_E_HIGH       0
`define UTC_E_MISS       1
`define UTC_E_WEAK       2
`define UTC_CMD_WR_BIT   6
`define UTC_CMD_ADDR     5:0

// ----------------------------------------------------------------------
// counts
// ----------------------------------------------------------------------
`define UTC_SETTLE_LEN   12'd128
`define UTC_STD_MIN      10'd30
`define UTC_THR_MAX      3'h7
`define UTC_ALL_EVENTS   6'd32
`define UTC_WIN_SHIFT    7
`define UTC_PRE_DIV0     4'd0
`define UTC_PRE_DIV1     4'd1
`define UTC_CMD_BITS     5'd8
`define UTC_FRAME_BITS   5'd16

`endif

// ===== core/utc_pkg.sv
/*
 * types shared by the time-of-flight control core and its serial slave.
 * assumes utc_cfg.svh is compiled alongside.
 */
package utc_pkg;

	// ------------------------------------------------------------------
	// sequencer states, gray along ready-tx-blank-settle-listen
	// ------------------------------------------------------------------
	typedef enum logic [2:0]
	{
		UTC_READY  = 3'h0,
		UTC_TX     = 3'h1,
		UTC_BLANK  = 3'h3,
		UTC_SETTLE = 3'h2,
		UTC_LISTEN = 3'h6
	} utc_seq_t;

	typedef logic [7:0] utc_byte_t;
	typedef logic [5:0] utc_addr_t;

endpackage : utc_pkg

// ===== core/utc_spi_slave.sv
/*
 * byte-wide serial register slave: command byte then data byte.
 * assumes chip select, serial clock and data are asynchronous pins and
 * that the serial clock is well below a sixth of the system clock.
 */
`timescale 1ns/1ns
`default_nettype none
`include "utc_cfg.svh"

module utc_spi_slave
(
	input  wire logic              clk,
	input  wire logic              rst,
	input  wire logic              cs_n_pin,
	input  wire logic              sclk_pin,
	input  wire logic              sdi_pin,
	input  wire utc_pkg::utc_byte_t rd_data,
	output var  utc_pkg::utc_addr_t addr,
	output var  logic              wr,
	output var  utc_pkg::utc_byte_t wr_data,
	output var  logic              serial_out,
	output var  logic              sdo_en
);
	import utc_pkg::*;

	typedef struct packed {
		logic [2:0] cs_s;
		logic [2:0] ck_s;
		logic [2:0] di_s;
		logic       cs_f;
		logic       ck_f;
		logic       di_f;
		logic [4:0] bits;
		utc_byte_t  shin;
		utc_addr_t  addr;
		logic       is_wr;
		utc_byte_t  shout;
		logic       oe;
		logic       wr;
	} utc_spi_t;

	utc_spi_t s;
	utc_spi_t next_s;

	// three-stage pin filter; value moves once stages two and three agree
	function automatic logic filt(input logic [2:0] sy, input logic f);
		filt = (sy[1] == sy[2]) ? sy[2] : f;
	endfunction : filt

	// ------------------------------------------------------------------
	// frame decoding
	// ------------------------------------------------------------------
	always_comb
	begin
		utc_byte_t sh;
		sh = 8'h00;
		next_s = s;
		next_s.wr = 1'b0;
		next_s.cs_s = {s.cs_s[1:0], cs_n_pin};
		next_s.ck_s = {s.ck_s[1:0], sclk_pin};
		next_s.di_s = {s.di_s[1:0], sdi_pin};
		next_s.cs_f = filt(s.cs_s, s.cs_f);
		next_s.ck_f = filt(s.ck_s, s.ck_f);
		next_s.di_f = filt(s.di_s, s.di_f);
		if (next_s.cs_f)
		begin
			next_s.bits = 5'h00;
			next_s.oe = 1'b0;
		end
		// idle level ignored; capture on rising edge
		else if (next_s.ck_f && !s.ck_f && s.bits != `UTC_FRAME_BITS)
		begin
			sh = {s.shin[6:0], next_s.di_f};
			next_s.shin = sh;
			next_s.bits = s.bits + 5'h01;
			if (s.bits == `UTC_CMD_BITS - 5'h01)
			begin
				next_s.addr = sh[`UTC_CMD_ADDR];
				next_s.is_wr = sh[`UTC_CMD_WR_BIT];
			end
			if (s.bits == `UTC_FRAME_BITS - 5'h01 && s.is_wr)
				next_s.wr = 1'b1;
		end
		// read data out on falling edge
		else if (!next_s.ck_f && s.ck_f && !s.is_wr)
		begin
			if (s.bits == `UTC_CMD_BITS && !s.oe)
			begin
				next_s.shout = rd_data;
				next_s.oe = 1'b1;
			end
			else if (s.bits > `UTC_CMD_BITS && s.oe)
				next_s.shout = {s.shout[6:0], 1'b0};
		end
	end

	// state register
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			s <= '{cs_s: 3'h7, ck_s: 3'h0, di_s: 3'h0, cs_f: 1'b1,
				default: '0};
		else
			s <= next_s;
	end

	assign addr = s.addr;
	assign wr = s.wr;
	assign wr_data = s.shin;
	assign serial_out = s.shout[7];
	assign sdo_en = s.oe;

	// ------------------------------------------------------------------
	// checks
	// ------------------------------------------------------------------
	property p_cs_abort;
		@(posedge clk) disable iff (rst)
		s.cs_f |=> (s.bits == 5'h00 && !s.oe);
	endproperty
	a_cs_abort: assert property (p_cs_abort)
		else $error("frame not aborted by chip select release");

	property p_wr_frame;
		@(posedge clk) disable iff (rst)
		s.wr |-> (s.bits == `UTC_FRAME_BITS && s.is_wr && !s.cs_f);
	endproperty
	a_wr_frame: assert property (p_wr_frame)
		else $error("write strobe outside a full write frame");

	property p_oe_read;
		@(posedge clk) disable iff (rst)
		s.oe |-> (!s.is_wr && !s.cs_f && s.bits >= `UTC_CMD_BITS);
	endproperty
	a_oe_read: assert property (p_oe_read)
		else $error("serial output driven outside a read");

endmodule : utc_spi_slave

`default_nettype wire

// ===== core/utc_core.sv
/*
 * time-of-flight measurement control: register file, sequencer for the
 * standard, blanked and short sequences, listening window with timeout,
 * error flags and active-low error pin.
 * assumes qualified stop pulses and the overrange level come from logic
 * on the same clock; all other inputs are asynchronous pins.
 */
`timescale 1ns/1ns
`default_nettype none
`include "utc_cfg.svh"

module utc_core
(
	input  wire logic SYS_CLK,
	input  wire logic RST,
	input  wire logic REF_CLOCK_IN,
	input  wire logic TRIGGER,
	input  wire logic ENABLE,
	input  wire logic QUALIFIED_STOP,
	input  wire logic SIGNAL_HIGH,
	input  wire logic CHIP_SELECT_N,
	input  wire logic SERIAL_CLK,
	input  wire logic SERIAL_IN,
	output var  logic SERIAL_OUT,
	output var  logic SERIAL_OUT_EN,
	output var  logic ERROR_PIN_N,
	output var  logic RX_ENABLE,
	output var  logic TX_ACTIVE,
	output var  logic LISTEN_WINDOW,
	output var  logic SETTLE_WINDOW,
	output var  logic MEASURE_BUSY
);
	import utc_pkg::*;

	typedef struct packed {
		logic [2:0]  ref_s;
		logic [2:0]  trg_s;
		logic [2:0]  en_s;
		logic        ref_f;
		logic        trg_f;
		logic        en_f;
		logic [3:0]  pre;
		utc_seq_t    seq;
		logic [11:0] cnt;
		logic [5:0]  events;
		logic        std;
		logic        blk;
		utc_byte_t   tx_burst;
		utc_byte_t   rx_count;
		utc_byte_t   afe_mode;
		utc_byte_t   thr_blank;
		utc_byte_t   rx_mode;
		utc_byte_t   wait_hi;
		utc_byte_t   wait_lo;
		utc_byte_t   listen;
		utc_byte_t   clk_scale;
		logic [2:0]  flags;
		logic        err_n;
		logic        rx_en;
		logic        tx_on;
		logic        lst;
		logic        stl;
		logic        busy;
	} utc_core_t;

	utc_core_t s;
	utc_core_t next_s;
	utc_addr_t spi_addr;
	logic      spi_wr;
	utc_byte_t spi_data;
	utc_byte_t rd_data;
	logic [9:0] wait_cnt;

	// ------------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------------

	// three-stage pin filter
	function automatic logic filt(input logic [2:0] sy, input logic f);
		filt = (sy[1] == sy[2]) ? sy[2] : f;
	endfunction : filt

	// register read mux; unlisted addresses read zero
	function automatic utc_byte_t read_reg(input utc_core_t r,
		input utc_addr_t a);
		case (a)
			`UTC_A_TX_BURST:  read_reg = r.tx_burst;
			`UTC_A_RX_COUNT:  read_reg = r.rx_count;
			`UTC_A_AFE_MODE:  read_reg = r.afe_mode;
			`UTC_A_THR_BLANK: read_reg = r.thr_blank;
			`UTC_A_RX_MODE:   read_reg = r.rx_mode;
			`UTC_A_WAIT_HI:   read_reg = r.wait_hi;
			`UTC_A_WAIT_LO:   read_reg = r.wait_lo;
			`UTC_A_ERR:       read_reg = {5'h00, r.flags};
			`UTC_A_LISTEN:    read_reg = r.listen;
			`UTC_A_CLK_SCALE: read_reg = r.clk_scale;
			default:          read_reg = 8'h00;
		endcase
	endfunction : read_reg

	// ------------------------------------------------------------------
	// serial register port
	// ------------------------------------------------------------------
	// serial slave clocked by the system clock; serial clock edges found from filtered pin samples
	utc_spi_slave u_spi
	(
		.clk      (SYS_CLK),
		.rst      (RST),
		.cs_n_pin (CHIP_SELECT_N),
		.sclk_pin (SERIAL_CLK),
		.sdi_pin  (SERIAL_IN),
		.rd_data  (rd_data),
		.addr     (spi_addr),
		.wr       (spi_wr),
		.wr_data  (spi_data),
		.serial_out      (SERIAL_OUT),
		.sdo_en   (SERIAL_OUT_EN)
	);

	assign rd_data = read_reg(s, spi_addr);

	// ten-bit wait count, also watched by the checks
	assign wait_cnt = {s.wait_hi[`UTC_WAIT_HI], s.wait_lo};

	// ------------------------------------------------------------------
	// next state
	// ------------------------------------------------------------------
	always_comb
	begin
		logic [9:0]  wcnt;
		logic        std_ok;
		logic        base_tick;
		logic        trig;
		logic        err_wr;
		logic        clr_sm;
		logic        clr_fl;
		logic [5:0]  expect_n;
		logic [11:0] window;
		logic [2:0]  set_fl;
		wcnt = 10'h000;
		std_ok = 1'b0;
		base_tick = 1'b0;
		trig = 1'b0;
		err_wr = 1'b0;
		clr_sm = 1'b0;
		clr_fl = 1'b0;
		expect_n = 6'h00;
		window = 12'h000;
		set_fl = 3'h0;
		next_s = s;

		next_s.ref_s = {s.ref_s[1:0], REF_CLOCK_IN};
		next_s.trg_s = {s.trg_s[1:0], TRIGGER};
		next_s.en_s = {s.en_s[1:0], ENABLE};
		next_s.ref_f = filt(s.ref_s, s.ref_f);
		next_s.trg_f = filt(s.trg_s, s.trg_f);
		next_s.en_f = filt(s.en_s, s.en_f);

		// base period from prescaled reference edges
		if (next_s.ref_f && !s.ref_f)
		begin
			if (s.pre == 4'h0)
			begin
				base_tick = 1'b1;
				next_s.pre = s.clk_scale[`UTC_PRE_BIT] ?
					`UTC_PRE_DIV1 : `UTC_PRE_DIV0;
			end
			else
				next_s.pre = s.pre - 4'h1;
		end

		// ten-bit wait count from high and low registers
		wcnt = wait_cnt;
		std_ok = (wcnt >= `UTC_STD_MIN) && !s.listen[`UTC_FORCE_BIT];
		trig = (next_s.trg_f != s.trg_f) &&
			(next_s.trg_f != s.rx_mode[`UTC_TRIG_POL_BIT]);
		expect_n = (s.rx_count[`UTC_NUM_RX] == 3'h0) ? `UTC_ALL_EVENTS :
			{3'h0, s.rx_count[`UTC_NUM_RX]};
		// listen window, extended in standard without blanking
		window = 12'({1'b0, s.listen[`UTC_WIN_SEL]} + 3'h1)
			<< `UTC_WIN_SHIFT;
		if (s.std && !s.blk)
			window = window + {2'h0, wcnt};

		// register writes
		if (spi_wr)
		begin
			case (spi_addr)
				`UTC_A_TX_BURST:  next_s.tx_burst = spi_data;
				`UTC_A_RX_COUNT:  next_s.rx_count = spi_data;
				`UTC_A_AFE_MODE:  next_s.afe_mode = spi_data;
				`UTC_A_THR_BLANK: next_s.thr_blank = spi_data;
				`UTC_A_RX_MODE:   next_s.rx_mode = spi_data;
				`UTC_A_WAIT_HI:   next_s.wait_hi = spi_data;
				`UTC_A_WAIT_LO:   next_s.wait_lo = spi_data;
				`UTC_A_ERR:       err_wr = 1'b1;
				`UTC_A_LISTEN:    next_s.listen = spi_data;
				`UTC_A_CLK_SCALE: next_s.clk_scale = spi_data;
				default:          err_wr = 1'b0;
			endcase
		end
		clr_sm = err_wr && spi_data[`UTC_E_MISS];
		clr_fl = err_wr && (spi_data[`UTC_E_HIGH]);

		// sequencer; counter runs down one step per base period
		if (base_tick && s.cnt != 12'h000)
			next_s.cnt = s.cnt - 12'h001;
		case (s.seq)
			UTC_READY:
			begin
				if (trig && s.en_f)
				begin
					next_s.events = 6'h00;
					next_s.std = std_ok;
					// blanking only on a standard sequence
					next_s.blk = std_ok && s.thr_blank[`UTC_BLANK_BIT];
					next_s.seq = std_ok ? UTC_TX : UTC_SETTLE;
					next_s.cnt = std_ok ? {7'h00, s.tx_burst[`UTC_NUM_TX]} :
						`UTC_SETTLE_LEN;
				end
			end
			UTC_TX:
			begin
				if (s.cnt == 12'h000)
				begin
					if (!s.std)
					begin
						next_s.seq = UTC_LISTEN;
						next_s.cnt = window;
					end
					else if (s.blk)
					begin
						next_s.seq = UTC_BLANK;
						next_s.cnt = {2'h0, wcnt};
					end
					else
					begin
						next_s.seq = UTC_SETTLE;
						next_s.cnt = `UTC_SETTLE_LEN;
					end
				end
			end
			UTC_BLANK:
			begin
				if (s.cnt == 12'h000)
				begin
					next_s.seq = UTC_SETTLE;
					next_s.cnt = `UTC_SETTLE_LEN;
				end
			end
			UTC_SETTLE:
			begin
				if (s.cnt == 12'h000)
				begin
					next_s.seq = s.std ? UTC_LISTEN : UTC_TX;
					next_s.cnt = s.std ? window :
						{7'h00, s.tx_burst[`UTC_NUM_TX]};
				end
			end
			UTC_LISTEN:
			begin
				if (SIGNAL_HIGH && s.thr_blank[`UTC_THR] == `UTC_THR_MAX)
					set_fl[`UTC_E_HIGH] = 1'b1;
				if (QUALIFIED_STOP)
					next_s.events = s.events + 6'h01;
				if (QUALIFIED_STOP && next_s.events == expect_n)
					next_s.seq = UTC_READY;
				else if (s.cnt == 12'h000 && !s.listen[`UTC_TMO_DIS_BIT])
				begin
					next_s.seq = UTC_READY;
					if (s.events != 6'h00)
						set_fl[`UTC_E_WEAK] = 1'b1;
					else
						set_fl[`UTC_E_MISS] = 1'b1;
				end
			end
			default:
				next_s.seq = UTC_READY;
		endcase

		// forced exit on clear write or enable low
		if (clr_sm || !s.en_f)
			next_s.seq = UTC_READY;

		next_s.flags = (clr_fl ? 3'h0 : s.flags) | set_fl;
		next_s.err_n = (next_s.flags == 3'h0);

		// registered pin levels from the coming state
		next_s.busy = (next_s.seq != UTC_READY);
		next_s.tx_on = (next_s.seq == UTC_TX);
		next_s.stl = (next_s.seq == UTC_SETTLE);
		next_s.lst = (next_s.seq == UTC_LISTEN);
		// receive chain off while blanking or in standard tx
		next_s.rx_en = next_s.stl || next_s.lst ||
			(next_s.tx_on && !next_s.std);
	end

	// state register
	always_ff @(posedge SYS_CLK or posedge RST)
	begin
		if (RST)
			s <= '{tx_burst: `UTC_R_TX_BURST, rx_count: `UTC_R_RX_COUNT,
				afe_mode: `UTC_R_AFE_MODE, thr_blank: `UTC_R_THR_BLANK,
				rx_mode: `UTC_R_RX_MODE, wait_hi: `UTC_R_WAIT_HI,
				wait_lo: `UTC_R_WAIT_LO, listen: `UTC_R_LISTEN,
				clk_scale: `UTC_R_CLK_SCALE, seq: UTC_READY,
				err_n: 1'b1, default: '0};
		else
			s <= next_s;
	end

	assign ERROR_PIN_N = s.err_n;
	assign RX_ENABLE = s.rx_en;
	assign TX_ACTIVE = s.tx_on;
	assign LISTEN_WINDOW = s.lst;
	assign SETTLE_WINDOW = s.stl;
	assign MEASURE_BUSY = s.busy;

	// ------------------------------------------------------------------
	// checks
	// ------------------------------------------------------------------
	sequence s_err_clear_sm;
		spi_wr && spi_addr == `UTC_A_ERR && spi_data[`UTC_E_MISS];
	endsequence

	sequence s_back_ready;
		##1 (s.seq == UTC_READY && !s.busy);
	endsequence

	property p_blank_std;
		@(posedge SYS_CLK) disable iff (RST)
		(s.seq == UTC_BLANK) |-> (s.std && s.blk && !s.rx_en);
	endproperty
	a_blank_std: assert property (p_blank_std)
		else $error("blanking outside a blanked standard sequence");

	property p_settle_len;
		@(posedge SYS_CLK) disable iff (RST)
		$rose(s.seq == UTC_SETTLE) |-> s.cnt == `UTC_SETTLE_LEN;
	endproperty
	a_settle_len: assert property (p_settle_len)
		else $error("settling window not loaded with 128");

	property p_timeout;
		@(posedge SYS_CLK) disable iff (RST)
		(s.seq == UTC_LISTEN && s.cnt == 12'h000 && !QUALIFIED_STOP &&
			!s.listen[`UTC_TMO_DIS_BIT] && !spi_wr)
		|-> s_back_ready ##0 (!s.err_n && s.flags[2:1] != 2'h0);
	endproperty
	a_timeout: assert property (p_timeout)
		else $error("timeout did not return to ready with error");

	property p_no_timeout;
		@(posedge SYS_CLK) disable iff (RST)
		(s.seq == UTC_LISTEN && s.listen[`UTC_TMO_DIS_BIT] &&
			!QUALIFIED_STOP && s.en_f && !spi_wr)
		|=> s.seq == UTC_LISTEN;
	endproperty
	a_no_timeout: assert property (p_no_timeout)
		else $error("receive left with timeout disabled");

	property p_clear_sm;
		@(posedge SYS_CLK) disable iff (RST)
		s_err_clear_sm |-> s_back_ready;
	endproperty
	a_clear_sm: assert property (p_clear_sm)
		else $error("sequencer not cleared by error write");

	property p_err_pin;
		@(posedge SYS_CLK) disable iff (RST)
		(s.flags != 3'h0) == !ERROR_PIN_N;
	endproperty
	a_err_pin: assert property (p_err_pin)
		else $error("error pin disagrees with flags");

	property p_high_thr;
		@(posedge SYS_CLK) disable iff (RST)
		$rose(s.flags[`UTC_E_HIGH]) |->
			$past(s.thr_blank[`UTC_THR]) == `UTC_THR_MAX;
	endproperty
	a_high_thr: assert property (p_high_thr)
		else $error("strong echo flag below top threshold");

	property p_std_sel;
		@(posedge SYS_CLK) disable iff (RST)
		(s.seq == UTC_READY ##1 s.seq == UTC_TX) |->
			s.std && $past(wait_cnt) >= `UTC_STD_MIN;
	endproperty
	a_std_sel: assert property (p_std_sel)
		else $error("standard sequence with short wait count");

endmodule : utc_core

`default_nettype wire

// ===== bench/utc_host.sv
/*
 * host model: serial master for the register port of the core.
 * assumes the system clock paces its bit timing, 6 cycles per half.
 */
`timescale 1ns/1ns
`default_nettype none

module utc_host
(
	input  wire logic clk,
	input  wire logic serial_out,
	input  wire logic sdo_en,
	output var  logic cs_n,
	output var  logic sclk,
	output var  logic serial_in
);
	logic idle = 1'b0;     // serial clock rest level
	logic wr_frame = 1'b0; // frame under way is a write
	logic en_bad = 1'b0;   // output driven during a write

	initial
	begin
		cs_n = 1'b1;
		sclk = 1'b0;
		serial_in = 1'b0;
	end

	task half;
		repeat (6) @(posedge clk);
		#1;
	endtask : half

	task frame(input logic [15:0] w, input int n, output logic [7:0] r);
		r = 8'h00;
		wr_frame = w[14];
		sclk = idle;
		half();
		cs_n = 1'b0;
		half();
		for (int i = 15; i > 15 - n; i--)
		begin
			sclk = 1'b0;
			serial_in = w[i];
			half();
			sclk = 1'b1;
			if (i < 8)
				r = {r[6:0], serial_out};
			half();
		end
		sclk = idle;
		serial_in = ~serial_in; // released line shows no stale value
		half();
		cs_n = 1'b1;
		half();
	endtask : frame

	// output enable watch during writes
	always @(posedge clk)
		if (sdo_en && !cs_n && wr_frame)
			en_bad <= 1'b1;
endmodule : utc_host
`default_nettype wire

// ===== bench/testbench.sv
/*
 * bench for the time-of-flight control core.
 * assumes the host model on the serial port and an 8-cycle ref tick.
 */
`timescale 1ns/1ns
`default_nettype none

module testbench;
	import utc_pkg::*;
	logic        sys_clk = 1'b0;
	logic        rst = 1'b1;
	logic        ref_clk = 1'b0;
	logic        trig = 1'b0;
	logic        enable = 1'b1;
	logic        stop = 1'b0;
	logic        sig_high = 1'b0;
	wire logic   cs_n, sclk, serial_in;
	logic        serial_out, sdo_en, err_n, rx_en, tx_on, listen, settle, busy;
	int          err_total = 0;
	int          compares = 0;
	int          cycles = 0;
	int          settle_ticks, listen_ticks, dark_ticks;
	utc_byte_t   st;
	logic [21:0] rows [0:5] = '{{6'h00, 8'ha5, 8'ha5}, {6'h02, 8'ha0, 8'ha0},
		{6'h06, 8'h1d, 8'h1d}, {6'h09, 8'hfe, 8'hfe}, {6'h2a, 8'h55, 8'h00},
		{6'h08, 8'h19, 8'h19}};
	utc_byte_t   rv [0:9] = '{8'h45, 8'h40, 8'h00, 8'h03, 8'h1f, 8'h00,
		8'h00, 8'h00, 8'h19, 8'h00};

	utc_core uut (.SYS_CLK(sys_clk), .RST(rst), .REF_CLOCK_IN(ref_clk),
		.TRIGGER(trig), .ENABLE(enable), .QUALIFIED_STOP(stop),
		.SIGNAL_HIGH(sig_high), .CHIP_SELECT_N(cs_n), .SERIAL_CLK(sclk),
		.SERIAL_IN(serial_in), .SERIAL_OUT(serial_out), .SERIAL_OUT_EN(sdo_en),
		.ERROR_PIN_N(err_n), .RX_ENABLE(rx_en), .TX_ACTIVE(tx_on),
		.LISTEN_WINDOW(listen), .SETTLE_WINDOW(settle), .MEASURE_BUSY(busy));
	utc_host host (.clk(sys_clk), .serial_out(serial_out), .sdo_en(sdo_en), .cs_n(cs_n),
		.sclk(sclk), .serial_in(serial_in));

	// ------------------------------------------------------------------
	// clocks, window tick counts, hang guard
	// ------------------------------------------------------------------
	initial
		forever #10 sys_clk = ~sys_clk;
	initial
		forever
		begin
			repeat (4) @(posedge sys_clk);
			#1 ref_clk = ~ref_clk;
		end
	always @(posedge ref_clk)
	begin
		settle_ticks <= settle_ticks + settle;
		listen_ticks <= listen_ticks + listen;
		dark_ticks <= dark_ticks + (busy && !rx_en && !tx_on);
	end
	always @(posedge sys_clk)
	begin
		cycles <= cycles + 1;
		if (cycles == 60000)
		begin
			err_total++;
			wrap_up();
		end
	end

	// ------------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------------
	task check(input logic [15:0] seen, input logic [15:0] exp);
		compares++;
		if (seen !== exp)
		begin
			err_total++;
			$display("ERROR %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task wrap_up;
		if (err_total == 0 && compares > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : wrap_up

	task wr(input utc_addr_t a, input utc_byte_t d);
		utc_byte_t r;
		host.frame({2'b01, a, d}, 16, r); // reserved bit zero
	endtask : wr

	task rchk(input utc_addr_t a, input utc_byte_t e);
		utc_byte_t r;
		host.frame({2'b00, a, 8'h00}, 16, r);
		check(r, e);
	endtask : rchk

	task automatic await(ref logic s, input logic v);
		for (int k = 0; k < 6000 && s !== v; k++)
			@(posedge sys_clk);
		#1;
		// a wait that runs out counts as a mismatch
		if (s !== v)
			err_total++;
	endtask : await

	// trigger, n stop pulses, read status after return to ready
	task automatic run(input int n, output utc_byte_t s);
		// clear away from a ref rise so the tick counters keep the zero
		wait (!ref_clk);
		settle_ticks = 0;
		listen_ticks = 0;
		dark_ticks = 0;
		trig = 1'b1;
		await(listen, 1'b1);
		trig = 1'b0;
		repeat (n)
		begin
			stop = 1'b1;
			@(posedge sys_clk);
			#1 stop = 1'b0;
			repeat (9) @(posedge sys_clk);
			#1;
		end
		await(busy, 1'b0);
		host.frame({2'b00, 6'h07, 8'h00}, 16, s);
	endtask : run

	// ------------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------------
	initial
	begin
		repeat (4) @(posedge sys_clk);
		#1 rst = 1'b0;
		repeat (6) @(posedge sys_clk);
		#1;
		for (int i = 0; i < 6; i++)
		begin
			host.idle = i[0];
			if (rows[i][21:16] < 6'h0a)
				wr(rows[i][21:16], rows[i][15:8]);
			rchk(rows[i][21:16], rows[i][7:0]);
		end
		rst = 1'b1;
		repeat (4) @(posedge sys_clk);
		#1 rst = 1'b0;
		check({busy, err_n}, 2'b01);
		repeat (6) @(posedge sys_clk);
		#1;
		for (int i = 0; i < 10; i++)
			rchk(i[5:0], rv[i]);
		host.frame({2'b01, 6'h02, 8'hff}, 12, st);
		rchk(6'h02, 8'h00);
		sig_high = 1'b1;
		run(0, st);
		check(st, 8'h02);
		check(err_n, 1'b0);
		check(settle_ticks >= 127 && settle_ticks <= 129, 1'b1);
		check(listen_ticks >= 255 && listen_ticks <= 257, 1'b1);
		sig_high = 1'b0;
		wr(6'h07, 8'h01);
		rchk(6'h07, 8'h00);
		check(err_n, 1'b1);
		run(1, st);
		check(st, 8'h04);
		wr(6'h07, 8'h03);
		rchk(6'h07, 8'h00);
		wr(6'h01, 8'h42);
		run(2, st);
		check({st, err_n}, 9'h001);
		check(listen_ticks < 250, 1'b1);
		wr(6'h06, 8'h1e);
		run(0, st);
		check(st, 8'h02);
		check(listen_ticks >= 285 && listen_ticks <= 287, 1'b1);
		check(dark_ticks == 0, 1'b1);
		wr(6'h07, 8'h03);
		wr(6'h03, 8'h0f);
		wr(6'h09, 8'h01);
		sig_high = 1'b1;
		run(0, st);
		sig_high = 1'b0;
		check(st, 8'h03);
		check(settle_ticks >= 254 && settle_ticks <= 258, 1'b1);
		check(listen_ticks >= 510 && listen_ticks <= 514, 1'b1);
		check(dark_ticks >= 58 && dark_ticks <= 62, 1'b1);
		wr(6'h07, 8'h01);
		check(err_n, 1'b1);
		wr(6'h09, 8'h00);
		wr(6'h06, 8'h00);
		wr(6'h08, 8'h1d);
		trig = 1'b1;
		await(listen, 1'b1);
		trig = 1'b0;
		repeat (3000) @(posedge sys_clk); // far below 100 ms
		#1 check(busy, 1'b1);
		wr(6'h07, 8'h03);
		check(busy, 1'b0);
		trig = 1'b1;
		await(listen, 1'b1);
		trig = 1'b0;
		enable = 1'b0;
		repeat (8) @(posedge sys_clk);
		#1 check(busy, 1'b0);
		check(host.en_bad, 1'b0);
		wrap_up();
	end
endmodule : testbench
`default_nettype wire
